// file: leih_hub.v
// Latched edge interrupt hub with flag, mask, raw status and control regs
// Summary of operation
// - One flag per input, set when its configured edge is seen.
// - First flag register holds pin and jack flags, both edges.
// - Overheat warning bit15 and shutdown bit0 flag both edges.
// - DC servo complete flag bit14 on rising edge only.
// - Core FIFO error flag bit12 on rising edge only.
// - Dynamics activity flags bits 11 and 9 on rising edge only.
// - Rate converter lock flags bits 8 and 7 on both edges.
// - Loop lock flags bits 6 and 5 on both edges.
// - Microphone detect flag bit1 on rising edge only.
// - Flags stay set until host writes one; only those bits clear.
// - Each input has its own mask bit.
// - Masked flags still set and read; never drive the request.
// - Request is OR of all unmasked flags.
// - Request holds until every unmasked set flag is cleared.
// - Global mask suppresses request; clear after reset.
// - Raw status register returns second-register input levels after debounce selection, except microphone detect.
// - Selectable debounce on overheat warning and shutdown inputs.
// - Request may be routed out on a general-purpose pin.
// - Mask bits reset to one; writing zero unmasks.
`timescale 1ns/1ps
`include "leih_regs.vh"
module leih_hub #(
    parameter DEB_CYC = `LEIH_DEB_CYC
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Register port
    input  wire [15:0] addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // Event inputs, laid out as the first flag register
    input  wire [15:0] events1_i,
    // Event inputs, laid out as the second flag register
    input  wire [15:0] events2_i,
    // Request outputs
    output wire        irq_o,
    output wire        irq_pin_o,
    output wire        irq_pin_oe_o
);

    reg  [15:0] flags1_reg;
    reg  [15:0] flags2_reg;
    reg  [15:0] mask1_reg;
    reg  [15:0] mask2_reg;
    reg  [15:0] ctrl_reg;
    reg  [15:0] prev1_reg;
    reg  [15:0] prev2_reg;
    reg         warn_deb_reg;
    reg         shut_deb_reg;
    reg  [31:0] warn_cnt_reg;
    reg  [31:0] shut_cnt_reg;
    wire [15:0] lvl2;
    wire [15:0] edge1;
    wire [15:0] edge2;
    wire [15:0] clr1;
    wire [15:0] clr2;
    wire        any_req;
    wire [15:0] flags1_view;
    wire [15:0] flags2_view;
    wire [15:0] mask1_view;
    wire [15:0] mask2_view;
    wire [15:0] raw2_view;
    // Named flags, one per event input
    wire        pin_eleven_edge_flag;
    wire        pin_ten_edge_flag;
    wire        pin_nine_edge_flag;
    wire        pin_eight_edge_flag;
    wire        jack_detect_flag;
    wire        pin_one_edge_flag;
    wire        overheat_warning_flag;
    wire        dc_servo_complete_flag;
    wire        core_fifo_error_flag;
    wire        second_dynamics_activity_flag;
    wire        first_dynamics_activity_flag;
    wire        second_rate_converter_lock_flag;
    wire        first_rate_converter_lock_flag;
    wire        second_loop_lock_flag;
    wire        first_loop_lock_flag;
    wire        microphone_detect_flag;
    wire        overheat_shutdown_flag;
    // Named mask bits
    wire        pin_eleven_mask;
    wire        pin_ten_mask;
    wire        pin_nine_mask;
    wire        pin_eight_mask;
    wire        jack_detect_mask;
    wire        pin_one_mask;
    wire        overheat_warning_mask;
    wire        dc_servo_complete_mask;
    wire        core_fifo_error_mask;
    wire        second_dynamics_activity_mask;
    wire        first_dynamics_activity_mask;
    wire        second_rate_converter_lock_mask;
    wire        first_rate_converter_lock_mask;
    wire        second_loop_lock_mask;
    wire        first_loop_lock_mask;
    wire        microphone_detect_mask;
    wire        overheat_shutdown_mask;
    // Named unmasked request terms
    wire        pin_eleven_req;
    wire        pin_ten_req;
    wire        pin_nine_req;
    wire        pin_eight_req;
    wire        jack_detect_req;
    wire        pin_one_req;
    wire        overheat_warning_req;
    wire        dc_servo_complete_req;
    wire        core_fifo_error_req;
    wire        second_dynamics_activity_req;
    wire        first_dynamics_activity_req;
    wire        second_rate_converter_lock_req;
    wire        first_rate_converter_lock_req;
    wire        second_loop_lock_req;
    wire        first_loop_lock_req;
    wire        microphone_detect_req;
    wire        overheat_shutdown_req;
    // Named live levels for raw readback
    wire        overheat_warning_level;
    wire        dc_servo_complete_level;
    wire        core_fifo_error_level;
    wire        second_dynamics_activity_level;
    wire        first_dynamics_activity_level;
    wire        second_rate_converter_lock_level;
    wire        first_rate_converter_lock_level;
    wire        second_loop_lock_level;
    wire        first_loop_lock_level;
    wire        overheat_shutdown_level;

    // Write strobe decode, used for every writable register
    function wr_hit;
        input [15:0] a;
        input [15:0] ofs;
        input        w;
        begin
            wr_hit = w && (a == ofs);
        end
    endfunction

    // Debounce: level only follows once stable for DEB_CYC cycles
    always @(posedge clk_i) begin
        if (rst_i) begin
            warn_deb_reg <= 1'b0;
            shut_deb_reg <= 1'b0;
            warn_cnt_reg <= 32'h00000000;
            shut_cnt_reg <= 32'h00000000;
        end else begin
            if (events2_i[15] == warn_deb_reg) begin
                warn_cnt_reg <= 32'h00000000;
            end else if (warn_cnt_reg >= DEB_CYC - 1) begin
                warn_deb_reg <= events2_i[15];
                warn_cnt_reg <= 32'h00000000;
            end else begin
                warn_cnt_reg <= warn_cnt_reg + 32'h00000001;
            end
            if (events2_i[0] == shut_deb_reg) begin
                shut_cnt_reg <= 32'h00000000;
            end else if (shut_cnt_reg >= DEB_CYC - 1) begin
                shut_deb_reg <= events2_i[0];
                shut_cnt_reg <= 32'h00000000;
            end else begin
                shut_cnt_reg <= shut_cnt_reg + 32'h00000001;
            end
        end
    end

    // Debounced or direct overheat levels feed the edge detector
    assign lvl2 = {ctrl_reg[`LEIH_CTRL_DEB_WARN] ? warn_deb_reg
                                                 : events2_i[15],
                   events2_i[14:1],
                   ctrl_reg[`LEIH_CTRL_DEB_SHUT] ? shut_deb_reg
                                                 : events2_i[0]};

    // Edge selection per bit
    assign edge1 = (events1_i ^ prev1_reg) & `LEIH_BOTH1;
    assign edge2 = ((lvl2 ^ prev2_reg) & `LEIH_BOTH2)
                 | (lvl2 & ~prev2_reg & `LEIH_RISE2);

    assign clr1 = wr_hit(addr_i, `LEIH_OFS_FLAGS1, wr_i) ? wdata_i
                                                         : 16'h0000;
    assign clr2 = wr_hit(addr_i, `LEIH_OFS_FLAGS2, wr_i) ? wdata_i
                                                         : 16'h0000;

    // Prior levels reset low: an input high at release flags once,
    // which the reset masks hide until software unmasks it
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev1_reg <= 16'h0000;
            prev2_reg <= 16'h0000;
        end else begin
            prev1_reg <= events1_i;
            prev2_reg <= lvl2;
        end
    end

    // Set wins over a clear in the same cycle, so no edge is lost
    always @(posedge clk_i) begin
        if (rst_i) begin
            flags1_reg <= 16'h0000;
            flags2_reg <= 16'h0000;
        end else begin
            flags1_reg <= ((flags1_reg & ~clr1) | edge1)
                        & `LEIH_FLAGS1_USED;
            flags2_reg <= ((flags2_reg & ~clr2) | edge2)
                        & `LEIH_FLAGS2_USED;
        end
    end

    // Mask and control registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask1_reg <= `LEIH_MASK1_RST;
            mask2_reg <= `LEIH_MASK2_RST;
            ctrl_reg  <= `LEIH_CTRL_RST;
        end else begin
            if (wr_hit(addr_i, `LEIH_OFS_MASK1, wr_i)) begin
                mask1_reg <= wdata_i & `LEIH_FLAGS1_USED;
            end
            if (wr_hit(addr_i, `LEIH_OFS_MASK2, wr_i)) begin
                mask2_reg <= wdata_i & `LEIH_FLAGS2_USED;
            end
            if (wr_hit(addr_i, `LEIH_OFS_CTRL, wr_i)) begin
                ctrl_reg <= wdata_i & `LEIH_CTRL_USED;
            end
        end
    end

    // Flags picked out by name
    assign pin_eleven_edge_flag = flags1_reg[10];
    assign pin_ten_edge_flag = flags1_reg[9];
    assign pin_nine_edge_flag = flags1_reg[8];
    assign pin_eight_edge_flag = flags1_reg[7];
    assign jack_detect_flag = flags1_reg[5];
    assign pin_one_edge_flag = flags1_reg[0];
    assign overheat_warning_flag = flags2_reg[15];
    assign dc_servo_complete_flag = flags2_reg[14];
    assign core_fifo_error_flag = flags2_reg[12];
    assign second_dynamics_activity_flag = flags2_reg[11];
    assign first_dynamics_activity_flag = flags2_reg[9];
    assign second_rate_converter_lock_flag = flags2_reg[8];
    assign first_rate_converter_lock_flag = flags2_reg[7];
    assign second_loop_lock_flag = flags2_reg[6];
    assign first_loop_lock_flag = flags2_reg[5];
    assign microphone_detect_flag = flags2_reg[1];
    assign overheat_shutdown_flag = flags2_reg[0];

    // Mask bits picked out by name
    assign pin_eleven_mask = mask1_reg[10];
    assign pin_ten_mask = mask1_reg[9];
    assign pin_nine_mask = mask1_reg[8];
    assign pin_eight_mask = mask1_reg[7];
    assign jack_detect_mask = mask1_reg[5];
    assign pin_one_mask = mask1_reg[0];
    assign overheat_warning_mask = mask2_reg[15];
    assign dc_servo_complete_mask = mask2_reg[14];
    assign core_fifo_error_mask = mask2_reg[12];
    assign second_dynamics_activity_mask = mask2_reg[11];
    assign first_dynamics_activity_mask = mask2_reg[9];
    assign second_rate_converter_lock_mask = mask2_reg[8];
    assign first_rate_converter_lock_mask = mask2_reg[7];
    assign second_loop_lock_mask = mask2_reg[6];
    assign first_loop_lock_mask = mask2_reg[5];
    assign microphone_detect_mask = mask2_reg[1];
    assign overheat_shutdown_mask = mask2_reg[0];

    // Unmasked terms; a masked flag still latches but never requests
    assign pin_eleven_req = pin_eleven_edge_flag
                          & ~pin_eleven_mask;
    assign pin_ten_req = pin_ten_edge_flag
                       & ~pin_ten_mask;
    assign pin_nine_req = pin_nine_edge_flag
                        & ~pin_nine_mask;
    assign pin_eight_req = pin_eight_edge_flag
                         & ~pin_eight_mask;
    assign jack_detect_req = jack_detect_flag
                           & ~jack_detect_mask;
    assign pin_one_req = pin_one_edge_flag
                       & ~pin_one_mask;
    assign overheat_warning_req = overheat_warning_flag
                                & ~overheat_warning_mask;
    assign dc_servo_complete_req = dc_servo_complete_flag
                                 & ~dc_servo_complete_mask;
    assign core_fifo_error_req = core_fifo_error_flag
                               & ~core_fifo_error_mask;
    assign second_dynamics_activity_req = second_dynamics_activity_flag
                                        & ~second_dynamics_activity_mask;
    assign first_dynamics_activity_req = first_dynamics_activity_flag
                                       & ~first_dynamics_activity_mask;
    assign second_rate_converter_lock_req = second_rate_converter_lock_flag
                                          & ~second_rate_converter_lock_mask;
    assign first_rate_converter_lock_req = first_rate_converter_lock_flag
                                         & ~first_rate_converter_lock_mask;
    assign second_loop_lock_req = second_loop_lock_flag
                                & ~second_loop_lock_mask;
    assign first_loop_lock_req = first_loop_lock_flag
                               & ~first_loop_lock_mask;
    assign microphone_detect_req = microphone_detect_flag
                                 & ~microphone_detect_mask;
    assign overheat_shutdown_req = overheat_shutdown_flag
                                 & ~overheat_shutdown_mask;

    // Request is combinational from flag and mask registers
    assign any_req = pin_eleven_req
                   | pin_ten_req
                   | pin_nine_req
                   | pin_eight_req
                   | jack_detect_req
                   | pin_one_req
                   | overheat_warning_req
                   | dc_servo_complete_req
                   | core_fifo_error_req
                   | second_dynamics_activity_req
                   | first_dynamics_activity_req
                   | second_rate_converter_lock_req
                   | first_rate_converter_lock_req
                   | second_loop_lock_req
                   | first_loop_lock_req
                   | microphone_detect_req
                   | overheat_shutdown_req;
    assign irq_o = any_req & ~ctrl_reg[`LEIH_CTRL_GMASK];
    assign irq_pin_o = irq_o;
    assign irq_pin_oe_o = ctrl_reg[`LEIH_CTRL_PIN_EN];

    // Read views rebuilt from named bits; unused positions read zero
    assign flags1_view = {5'h00, pin_eleven_edge_flag, pin_ten_edge_flag,
                          pin_nine_edge_flag, pin_eight_edge_flag, 1'b0,
                          jack_detect_flag, 4'h0, pin_one_edge_flag};
    assign flags2_view = {overheat_warning_flag, dc_servo_complete_flag, 1'b0,
                          core_fifo_error_flag, second_dynamics_activity_flag,
                          1'b0, first_dynamics_activity_flag,
                          second_rate_converter_lock_flag,
                          first_rate_converter_lock_flag,
                          second_loop_lock_flag, first_loop_lock_flag, 3'h0,
                          microphone_detect_flag, overheat_shutdown_flag};
    assign mask1_view = {5'h00, pin_eleven_mask, pin_ten_mask, pin_nine_mask,
                         pin_eight_mask, 1'b0, jack_detect_mask, 4'h0,
                         pin_one_mask};
    assign mask2_view = {overheat_warning_mask, dc_servo_complete_mask, 1'b0,
                         core_fifo_error_mask, second_dynamics_activity_mask,
                         1'b0, first_dynamics_activity_mask,
                         second_rate_converter_lock_mask,
                         first_rate_converter_lock_mask,
                         second_loop_lock_mask, first_loop_lock_mask, 3'h0,
                         microphone_detect_mask, overheat_shutdown_mask};

    // Raw levels are after debounce selection, so they match the flags
    assign overheat_warning_level = lvl2[15];
    assign dc_servo_complete_level = lvl2[14];
    assign core_fifo_error_level = lvl2[12];
    assign second_dynamics_activity_level = lvl2[11];
    assign first_dynamics_activity_level = lvl2[9];
    assign second_rate_converter_lock_level = lvl2[8];
    assign first_rate_converter_lock_level = lvl2[7];
    assign second_loop_lock_level = lvl2[6];
    assign first_loop_lock_level = lvl2[5];
    assign overheat_shutdown_level = lvl2[0];
    assign raw2_view = {overheat_warning_level, dc_servo_complete_level, 1'b0,
                        core_fifo_error_level, second_dynamics_activity_level,
                        1'b0, first_dynamics_activity_level,
                        second_rate_converter_lock_level,
                        first_rate_converter_lock_level,
                        second_loop_lock_level, first_loop_lock_level, 4'h0,
                        overheat_shutdown_level};

    // Read data one cycle after the strobe; reads change no state
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `LEIH_OFS_FLAGS1: rdata_o <= flags1_view;
                `LEIH_OFS_FLAGS2: rdata_o <= flags2_view;
                `LEIH_OFS_RAW2:   rdata_o <= raw2_view;
                `LEIH_OFS_MASK1:  rdata_o <= mask1_view;
                `LEIH_OFS_MASK2:  rdata_o <= mask2_view;
                `LEIH_OFS_CTRL:   rdata_o <= ctrl_reg;
                default:          rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

endmodule // leih_hub

// file: leih_regs.vh
// Register offsets, field positions, reset values and timing for the hub
`ifndef LEIH_REGS_VH
`define LEIH_REGS_VH
`define LEIH_ADDR_W          16
`define LEIH_OFS_FLAGS1      16'h0730
`define LEIH_OFS_FLAGS2      16'h0731
`define LEIH_OFS_RAW2        16'h0732
`define LEIH_OFS_MASK1       16'h0738
`define LEIH_OFS_MASK2       16'h0739
`define LEIH_OFS_CTRL        16'h0740
`define LEIH_FLAGS1_USED     16'h07A1
`define LEIH_FLAGS2_USED     16'hDBE3
`define LEIH_BOTH1           16'h07A1
`define LEIH_BOTH2           16'h81E1
`define LEIH_RISE2           16'h5A02
`define LEIH_MASK1_RST       16'h07A1
`define LEIH_MASK2_RST       16'hDBE3
`define LEIH_CTRL_GMASK      0
`define LEIH_CTRL_DEB_WARN   1
`define LEIH_CTRL_DEB_SHUT   2
`define LEIH_CTRL_PIN_EN     3
`define LEIH_CTRL_USED       16'h000F
`define LEIH_CTRL_RST        16'h0000
`define LEIH_DEB_TIME_US     100
`define LEIH_CLK_MHZ         40
`define LEIH_DEB_CYC         (`LEIH_DEB_TIME_US * `LEIH_CLK_MHZ)
`endif

// file: leih_hub_properties.sv
// Port checks for the interrupt hub
`timescale 1ns/1ps
`include "leih_regs.vh"
module leih_hub_props (
    input wire        clk_i,
    input wire        rst_i,
    input wire [15:0] addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    input wire [15:0] events1_i,
    input wire [15:0] events2_i,
    input wire        irq_o,
    input wire        irq_pin_o,
    input wire        irq_pin_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire ctl = wr_i && addr_i == `LEIH_OFS_CTRL;
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    a_pin_follow: assert property (irq_pin_o == irq_o)
        else $error("pin differs from request");
    a_flags_one: assert property (rd_i && addr_i == `LEIH_OFS_FLAGS1
        |=> (rdata_o & ~`LEIH_FLAGS1_USED) == 16'h0000) else $error("bad bit");
    a_flags_two: assert property (rd_i && addr_i == `LEIH_OFS_FLAGS2
        |=> (rdata_o & ~`LEIH_FLAGS2_USED) == 16'h0000) else $error("bad bit");
    a_reset_quiet: assert property ($past(rst_i)
        |-> !irq_o && !irq_pin_oe_o) else $error("request after reset");
    a_raw_level: assert property (rd_i && addr_i == `LEIH_OFS_RAW2
        && $stable(events2_i) |=> (rdata_o & 16'h5BE0) ==
        ($past(events2_i) & 16'h5BE0)) else $error("raw level wrong");
    a_gmask_quiet: assert property (ctl && wdata_i[0] |=> !irq_o)
        else $error("request while masked");
    a_oe_ctrl: assert property (ctl
        |=> irq_pin_oe_o == $past(wdata_i[3])) else $error("pin enable wrong");
    cover property (irq_o ##1 !irq_o);
    cover property (irq_pin_oe_o && irq_pin_o);
    cover property (rd_i ##1 rdata_o != 16'h0000);
endmodule // leih_hub_props
bind leih_hub leih_hub_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .events1_i(events1_i), .events2_i(events2_i),
    .irq_o(irq_o), .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));

// file: leih_host.sv
// Host model that services the hub over its register port
`timescale 1ns/1ps
module leih_host (
    input  wire        clk_i,
    output reg  [15:0] addr_o = 16'h0000,
    output reg  [15:0] wdata_o = 16'h0000,
    output reg         wr_o = 1'b0,
    output reg         rd_o = 1'b0,
    input  wire [15:0] rdata_i
);
    // Clears by writing ones; strobe held exactly one cycle
    task wr(input [15:0] a, input [15:0] d);
        begin
            @(posedge clk_i) {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
            @(posedge clk_i) wr_o <= 1'b0;
        end
    endtask
    // Data stand only in the cycle after the strobe
    task rd(input [15:0] a, output [15:0] d);
        begin
            @(posedge clk_i) {addr_o, rd_o} <= {a, 1'b1};
            @(posedge clk_i) rd_o <= 1'b0;
            @(negedge clk_i) d = rdata_i;
        end
    endtask
endmodule // leih_host

// file: leih_hub_test.sv
// Self-checking bench for the interrupt hub
`timescale 1ns/1ps
`include "leih_regs.vh"
module leih_hub_test;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [15:0] e1 = 16'h0000, e2 = 16'h0000, v;
    wire [15:0] ad, wd, rdata;
    wire        wr, rd, irq, pin, oe;
    integer     err_total = 0, total_checks = 0;
    initial forever #12.5 clk_i = ~clk_i;
    leih_host HOST (.clk_i(clk_i), .addr_o(ad), .wdata_o(wd), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata));
    leih_hub #(.DEB_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(ad),
        .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .events1_i(e1),
        .events2_i(e2), .irq_o(irq), .irq_pin_o(pin), .irq_pin_oe_o(oe));
    task chk(input [15:0] s, input [15:0] x);
        begin
            total_checks = total_checks + 1;
            if (s !== x) begin
                err_total = err_total + 1;
                $display("Error at %0t: seen %h expected %h", $time, s, x);
            end
        end
    endtask
    task rc(input [15:0] a, input [15:0] x); begin HOST.rd(a, v); chk(v, x); end
    endtask
    task ci(input [1:0] x); begin @(negedge clk_i) chk({oe, irq}, x); end
    endtask
    task cyc(input integer n); repeat (n) @(posedge clk_i);
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task t_edges; // Every input up, then every input down
        begin
            HOST.wr(`LEIH_OFS_MASK1, 16'h0000);
            HOST.wr(`LEIH_OFS_MASK2, 16'h0000);
            @(posedge clk_i) {e1, e2} <= 32'hFFFFFFFF;
            cyc(2);
            rc(`LEIH_OFS_FLAGS1, `LEIH_FLAGS1_USED);
            rc(`LEIH_OFS_FLAGS2, `LEIH_FLAGS2_USED);
            rc(`LEIH_OFS_RAW2, 16'hDBE1);
            ci(2'b01);
            HOST.wr(`LEIH_OFS_FLAGS1, 16'hFFFF);
            HOST.wr(`LEIH_OFS_FLAGS2, 16'hFFFF);
            ci(2'b00);
            @(posedge clk_i) {e1, e2} <= 32'h0;
            cyc(2);
            rc(`LEIH_OFS_FLAGS1, `LEIH_BOTH1);
            rc(`LEIH_OFS_FLAGS2, `LEIH_BOTH2);
            HOST.wr(`LEIH_OFS_FLAGS1, 16'hFFFF);
            HOST.wr(`LEIH_OFS_FLAGS2, 16'hFFFF);
        end
    endtask
    task t_w1c; // Partial clears, masking, pin routing
        begin
            @(posedge clk_i) e2 <= 16'h4000;
            cyc(2);
            HOST.wr(`LEIH_OFS_FLAGS2, 16'hBFFF);
            HOST.wr(`LEIH_OFS_FLAGS2, 16'h0000);
            rc(`LEIH_OFS_FLAGS2, 16'h4000);
            ci(2'b01);
            HOST.wr(`LEIH_OFS_MASK2, 16'h4000);
            ci(2'b00);
            rc(`LEIH_OFS_FLAGS2, 16'h4000);
            HOST.wr(`LEIH_OFS_MASK2, 16'h0000);
            HOST.wr(`LEIH_OFS_CTRL, 16'h0009);
            ci(2'b10);
            HOST.wr(`LEIH_OFS_CTRL, 16'h0008);
            ci(2'b11);
            @(posedge clk_i) e2 <= 16'h0000;
            HOST.wr(`LEIH_OFS_FLAGS2, 16'h4000);
            cyc(2);
            rc(`LEIH_OFS_FLAGS2, 16'h0000);
        end
    endtask
    task t_deb; // Short glitch filtered, long level accepted
        begin
            HOST.wr(`LEIH_OFS_CTRL, 16'h0006);
            HOST.wr(`LEIH_OFS_FLAGS2, 16'hFFFF);
            @(posedge clk_i) e2 <= 16'h8001;
            cyc(2);
            e2 <= 16'h0000;
            cyc(8);
            rc(`LEIH_OFS_FLAGS2, 16'h0000);
            @(posedge clk_i) e2 <= 16'h8001;
            cyc(10);
            rc(`LEIH_OFS_FLAGS2, 16'h8001);
        end
    endtask
    initial begin
        cyc(4);
        rst_i <= 1'b0;
        rc(`LEIH_OFS_MASK1, `LEIH_MASK1_RST);
        rc(`LEIH_OFS_MASK2, `LEIH_MASK2_RST);
        rc(`LEIH_OFS_CTRL, `LEIH_CTRL_RST);
        rc(16'h0700, 16'h0000);
        t_edges;
        t_w1c;
        t_deb;
        wrap_up;
    end
    // Cut a hang short
    initial begin #100000; err_total = err_total + 1; wrap_up; end
endmodule // leih_hub_test
